// >>> src/ocp_pkg.sv
/*
 * constants shared by the output compare channel and its host end.
 * assumes a single 100 MHz clock domain on both ends.
 */
package ocp_pkg;
   localparam int unsigned CNT_W        = 16;
   localparam int unsigned CTL_W        = 16;
   localparam int unsigned MODE_LSB     = 0;
   localparam int unsigned MODE_W       = 3;
   localparam int unsigned TSEL_BIT     = 3;
   localparam int unsigned FLT_BIT      = 4;
   localparam int unsigned TON_BIT      = 15;
   localparam logic [CTL_W-1:0] CTL_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;

   typedef enum logic [2:0] {
      OCP_OFF    = 3'h0,
      OCP_LOW    = 3'h1,
      OCP_HIGH   = 3'h2,
      OCP_TOGGLE = 3'h3,
      OCP_SINGLE = 3'h4,
      OCP_CONT   = 3'h5,
      OCP_PWM    = 3'h6,
      OCP_PWMF   = 3'h7
   } ocp_mode_e;

   // register select codes on the host write port
   typedef enum logic [1:0] {
      OCP_SEL_CTL  = 2'h0,
      OCP_SEL_PRI  = 2'h1,
      OCP_SEL_SEC  = 2'h2,
      OCP_SEL_TMR  = 2'h3
   } ocp_sel_e;
endpackage

// >>> src/ocp_if.sv
/*
 * interface joining the host (timers, register writes) and the compare channel.
 * the testbench resolves the tri-state pin from compare_output_pin and compare_output_oe_n.
 */
`timescale 1ns/10ps
interface ocp_if (
   input wire logic clk,
   input wire logic rstn
);
   logic [ocp_pkg::CNT_W-1:0] first_timer_count;
   logic [ocp_pkg::CNT_W-1:0] second_timer_count;
   logic                      first_timer_wrap;
   logic                      second_timer_wrap;
   logic                      wr_en;
   ocp_pkg::ocp_sel_e         wr_sel;
   logic [ocp_pkg::CNT_W-1:0] wr_data;
   logic [ocp_pkg::CTL_W-1:0] compare_control_reg;
   logic [ocp_pkg::CNT_W-1:0] primary_compare_value;
   logic [ocp_pkg::CNT_W-1:0] secondary_compare_value;

   modport host (
      output first_timer_count, second_timer_count, first_timer_wrap, second_timer_wrap,
      output wr_en, wr_sel, wr_data,
      input  compare_control_reg, primary_compare_value, secondary_compare_value
   );
   modport dev (
      input  first_timer_count, second_timer_count, first_timer_wrap, second_timer_wrap,
      input  wr_en, wr_sel, wr_data,
      output compare_control_reg, primary_compare_value, secondary_compare_value
   );
endinterface

// >>> src/ocp_host.sv
/*
 * host end: two 16-bit timers with period and on bit, plus a register write port.
 * assumes the user side issues one write per cycle at most.
 */
`timescale 1ns/10ps
module ocp_host (
   input  wire logic                      clk,
   input  wire logic                      rstn,
   ocp_if.host                            bus,
   input  wire logic                      user_wr_en,
   input  wire ocp_pkg::ocp_sel_e         user_wr_sel,
   input  wire logic                      user_wr_timer,
   input  wire logic [ocp_pkg::CNT_W-1:0] user_wr_data,
   output logic [ocp_pkg::CTL_W-1:0]      user_control,
   output logic [ocp_pkg::CNT_W-1:0]      user_primary,
   output logic [ocp_pkg::CNT_W-1:0]      user_secondary
);
   // ****************************************
   // timers
   // ****************************************
   // the timer control write (sel TMR) carries the on bit at bit 15 and the period
   // in the low bits with bit 15 masked; host must set period >= secondary [R7]
   // and load compare values before turning the timer on [R8] [R12]
   logic [ocp_pkg::CNT_W-1:0] cnt       [2];
   logic [ocp_pkg::CNT_W-1:0] next_cnt  [2];
   logic [ocp_pkg::CNT_W-1:0] per       [2];
   logic [ocp_pkg::CNT_W-1:0] next_per  [2];
   logic [1:0]                on;
   logic [1:0]                next_on;
   logic [1:0]                wrap;

   generate
      for (genvar i = 0; i < 2; i++) begin : g_tmr
         always_comb begin
            next_cnt[i] = cnt[i];
            next_per[i] = per[i];
            next_on[i]  = on[i];
            wrap[i]     = on[i] && (cnt[i] == per[i]);
            if (on[i]) begin
               next_cnt[i] = wrap[i] ? ocp_pkg::CNT_ZERO : cnt[i] + ocp_pkg::CNT_ONE;
            end
            if (user_wr_en && user_wr_sel == ocp_pkg::OCP_SEL_TMR && user_wr_timer == 1'(i)) begin
               next_on[i]  = user_wr_data[ocp_pkg::TON_BIT];
               next_per[i] = {1'b0, user_wr_data[ocp_pkg::CNT_W-2:0]};
               if (!user_wr_data[ocp_pkg::TON_BIT]) begin
                  next_cnt[i] = ocp_pkg::CNT_ZERO;
               end
            end
         end
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               cnt[i] <= ocp_pkg::CNT_ZERO;
               per[i] <= ocp_pkg::CNT_ZERO;
               on[i]  <= 1'b0;
            end else begin
               cnt[i] <= next_cnt[i];
               per[i] <= next_per[i];
               on[i]  <= next_on[i];
            end
         end
      end
   endgenerate

   assign bus.first_timer_count  = cnt[0];
   assign bus.second_timer_count = cnt[1];
   assign bus.first_timer_wrap   = wrap[0];
   assign bus.second_timer_wrap  = wrap[1];
   // rewriting mode 100 re-arms a single pulse; this end just forwards it [R9]
   // host clears the fault state by rewriting the pwm mode once the fault pin is high [R15]
   assign bus.wr_en   = user_wr_en && user_wr_sel != ocp_pkg::OCP_SEL_TMR;
   assign bus.wr_sel  = user_wr_sel;
   assign bus.wr_data = user_wr_data; // start in primary, stop in secondary [R6]
   assign user_control   = bus.compare_control_reg;
   assign user_primary   = bus.primary_compare_value;
   assign user_secondary = bus.secondary_compare_value;
endmodule

// >>> src/ocp_chan.sv
/*
 * one output compare channel: simple match, single/continuous pulse, buffered pwm
 * with fault tri-state. assumes timer counts and wrap pulses arrive on clk.
 */
// Summary of operation
// [R1] control bit 3 picks timer, default first
// [R2] modes 001 low, 010 high, 011 toggle
// [R3] simple modes match primary against timer count
// [R4] wrap without match leaves pin unchanged
// [R5] 100 single pulse, 101 continuous pulse
// [R6] host loads start primary, stop secondary
// [R7] host sets period not below secondary
// [R8] single pulse: values, mode, then timer on
// [R9] each rewrite of 100 arms one pulse
// [R10] 110/111 pwm; primary read-only, secondary buffer
// [R11] duty changes reach output without glitch
// [R12] host starts pwm in documented order
// [R13] mode 111 low fault tri-states output
// [R14] control bit 4 flags a fault
// [R15] resume only after fault high and rewrite
// [R16] period match copies buffer, drives high
// [R17] pwm low at main match; pulse rise/fall
`timescale 1ns/10ps
module ocp_chan (
   input  wire logic clk,
   input  wire logic rstn,
   ocp_if.dev        bus,
   input  wire logic fault_input_pins,
   output logic      compare_output_pin,
   output logic      compare_output_oe_n
);
   // ****************************************
   // fault synchroniser
   // ****************************************
   logic flt_meta;
   logic flt_sync;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flt_meta <= 1'b1;
         flt_sync <= 1'b1;
      end else begin
         flt_meta <= fault_input_pins;
         flt_sync <= flt_meta;
      end
   end

   // ****************************************
   // channel state
   // ****************************************
   logic [ocp_pkg::CTL_W-1:0] ctl;
   logic [ocp_pkg::CTL_W-1:0] next_ctl;
   logic [ocp_pkg::CNT_W-1:0] pri;
   logic [ocp_pkg::CNT_W-1:0] next_pri;
   logic [ocp_pkg::CNT_W-1:0] sec;
   logic [ocp_pkg::CNT_W-1:0] next_sec;
   logic                      pin;
   logic                      next_pin;
   logic                      armed;
   logic                      next_armed;
   logic                      flt;
   logic                      next_flt;
   logic                      hiz;
   logic                      next_hiz;

   ocp_pkg::ocp_mode_e        mode;
   logic [ocp_pkg::CNT_W-1:0] count;
   logic                      wrap;
   logic                      wr_ctl;
   logic                      pwm;

   // ****************************************
   // timer select and mode decode
   // ****************************************
   // the timer pick follows the stored control word, so a write that swaps
   // timers only takes effect from the next compare cycle on
   always_comb begin
      mode  = ocp_pkg::ocp_mode_e'(ctl[ocp_pkg::MODE_LSB +: ocp_pkg::MODE_W]);
      count = ctl[ocp_pkg::TSEL_BIT] ? bus.second_timer_count : bus.first_timer_count; // R1
      wrap  = ctl[ocp_pkg::TSEL_BIT] ? bus.second_timer_wrap : bus.first_timer_wrap;
      pwm   = (mode == ocp_pkg::OCP_PWM) || (mode == ocp_pkg::OCP_PWMF); // R10
      wr_ctl = bus.wr_en && bus.wr_sel == ocp_pkg::OCP_SEL_CTL;
   end

   // ****************************************
   // next state
   // ****************************************
   // one process owns every next value so the priority between the mode action
   // and a host write sits in one place: the write is applied last
   always_comb begin
      next_ctl   = ctl;
      next_pri   = pri;
      next_sec   = sec;
      next_pin   = pin;
      next_armed = armed;
      next_flt   = flt;
      next_hiz   = hiz;

      // output behaviour for the mode in force this cycle
      unique case (mode)
         ocp_pkg::OCP_OFF: begin
            next_pin = 1'b0;
         end
         ocp_pkg::OCP_LOW, ocp_pkg::OCP_HIGH, ocp_pkg::OCP_TOGGLE: begin
            // a wrap alone never touches the pin, only an exact match does
            if (count == pri) begin // R3 R4
               unique case (mode)
                  ocp_pkg::OCP_LOW:  next_pin = 1'b0; // R2
                  ocp_pkg::OCP_HIGH: next_pin = 1'b1; // R2
                  default:           next_pin = ~pin; // R2
               endcase
            end
         end
         ocp_pkg::OCP_SINGLE, ocp_pkg::OCP_CONT: begin // R5
            if (armed && count == pri) begin
               next_pin = 1'b1; // R17
            end
            // the fall needs the pin high, so a stop time met before the start
            // time cannot end a pulse that never began
            if (armed && count == sec && pin) begin
               next_pin = 1'b0; // R17
               if (mode == ocp_pkg::OCP_SINGLE) begin
                  next_armed = 1'b0; // R9
               end
            end
         end
         ocp_pkg::OCP_PWM, ocp_pkg::OCP_PWMF: begin
            // the main latch only moves at the period boundary, so a duty write
            // mid-period cannot shorten or split the pulse in flight
            if (wrap) begin
               next_pri = sec; // R11 R16
               next_pin = 1'b1; // R16
            end else if (count == pri) begin
               next_pin = 1'b0; // R17
            end
            // the fault pin is seen only after two flops: a low shorter than one
            // clock may be missed, traded for a clean metastability margin
            if (mode == ocp_pkg::OCP_PWMF && !flt_sync) begin
               next_hiz = 1'b1; // R13
               next_flt = 1'b1; // R14
            end
         end
      endcase

      // host writes; the fault flag bit is not writable
      if (bus.wr_en) begin
         unique case (bus.wr_sel)
            ocp_pkg::OCP_SEL_CTL: begin
               next_ctl = bus.wr_data;
               next_ctl[ocp_pkg::FLT_BIT] = 1'b0;
               next_armed = 1'b1; // R9
               // clearing needs the synced fault pin high while the set above needs
               // it low, so a set and a clear never meet in one cycle
               if (flt_sync) begin // R15
                  next_hiz = 1'b0;
                  next_flt = 1'b0;
               end
            end
            ocp_pkg::OCP_SEL_PRI: begin
               if (!pwm) begin
                  next_pri = bus.wr_data; // R10
               end
            end
            ocp_pkg::OCP_SEL_SEC: next_sec = bus.wr_data;
            default: ;
         endcase
      end
      // writing mode 000 parks the pin low at once rather than a cycle later
      if (wr_ctl && next_ctl[ocp_pkg::MODE_LSB +: ocp_pkg::MODE_W] == ocp_pkg::OCP_OFF) begin
         next_pin = 1'b0;
      end
   end

   // ****************************************
   // state registers
   // ****************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl   <= ocp_pkg::CTL_RST;
         pri   <= ocp_pkg::CNT_ZERO;
         sec   <= ocp_pkg::CNT_ZERO;
         pin   <= 1'b0;
         armed <= 1'b0;
         flt   <= 1'b0;
         hiz   <= 1'b0;
      end else begin
         ctl   <= next_ctl;
         pri   <= next_pri;
         sec   <= next_sec;
         pin   <= next_pin;
         armed <= next_armed;
         flt   <= next_flt;
         hiz   <= next_hiz;
      end
   end

   // ****************************************
   // readback and pin
   // ****************************************
   // the flag is overlaid here; the stored control word always keeps that bit clear
   always_comb begin
      bus.compare_control_reg = ctl;
      bus.compare_control_reg[ocp_pkg::FLT_BIT] = flt; // R14
   end
   assign bus.primary_compare_value   = pri;
   assign bus.secondary_compare_value = sec;
   assign compare_output_pin  = pin;
   assign compare_output_oe_n = hiz; // R13 R15
endmodule

// >>> sim/ocp_props.sv
/* assertions on the host to channel link and the channel pin.
   assumes one clock domain; instanced by the bench top beside the link. */
`timescale 1ns/10ps
module ocp_props (
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic [15:0]       first_timer_count,
   input wire logic [15:0]       second_timer_count,
   input wire logic              first_timer_wrap,
   input wire logic              second_timer_wrap,
   input wire logic              wr_en,
   input wire ocp_pkg::ocp_sel_e wr_sel,
   input wire logic [15:0]       wr_data,
   input wire logic [15:0]       compare_control_reg,
   input wire logic [15:0]       primary_compare_value,
   input wire logic [15:0]       secondary_compare_value,
   input wire logic              fault_input_pins,
   input wire logic              compare_output_pin,
   input wire logic              compare_output_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [2:0]  mode;
   logic [15:0] cnt;
   logic        wrap;
   logic        ctl_wr;
   assign mode = compare_control_reg[2:0];
   assign cnt = compare_control_reg[3] ? second_timer_count : first_timer_count;
   assign wrap = compare_control_reg[3] ? second_timer_wrap : first_timer_wrap;
   assign ctl_wr = wr_en && wr_sel == ocp_pkg::OCP_SEL_CTL;
   // ****************
   // sequences
   // ****************
   sequence pwm_wrap;
      !wr_en && mode == 3'h6 && wrap;
   endsequence
   sequence fault_seen;
      (mode == 3'h7 && !fault_input_pins) [*3];
   endsequence
   tsel_store_a: assert property (
      ctl_wr |=> compare_control_reg[3:0] == $past(wr_data[3:0])) else $error("control field lost");
   sec_store_a: assert property (
      wr_en && wr_sel == ocp_pkg::OCP_SEL_SEC |=> secondary_compare_value == $past(wr_data))
      else $error("buffer latch lost");
   main_lock_a: assert property (
      mode[2:1] == 2'h3 && !wrap |=> $stable(primary_compare_value)) else $error("main latch moved");
   simple_match_a: assert property (
      !wr_en && mode inside {3'h1, 3'h2, 3'h3} && cnt == primary_compare_value |=>
      compare_output_pin == ($past(mode) == 3'h3 ? !$past(compare_output_pin) : $past(mode) == 3'h2))
      else $error("match action wrong");
   no_match_a: assert property (
      !wr_en && mode inside {3'h1, 3'h2, 3'h3} && cnt != primary_compare_value |=>
      $stable(compare_output_pin)) else $error("pin moved without match");
   pwm_load_a: assert property (
      pwm_wrap |=> compare_output_pin && primary_compare_value == $past(secondary_compare_value))
      else $error("period load wrong");
   pwm_fall_a: assert property (
      !wr_en && mode == 3'h6 && !wrap && cnt == primary_compare_value |=> !compare_output_pin)
      else $error("duty end missed");
   fault_tri_a: assert property (
      fault_seen |-> ##[0:2] (compare_output_oe_n && compare_control_reg[4])) else $error("fault not taken");
   fault_hold_a: assert property (
      compare_output_oe_n && !ctl_wr |=> compare_output_oe_n) else $error("left tri-state early");
endmodule

// >>> sim/output_compare_pwm_channel_tb_top.sv
/* bench top: host end and channel joined by the link, compared with a cycle model.
   assumes the host passes writes through in the cycle they are made. */
`timescale 1ns/10ps
module output_compare_pwm_channel_tb_top;
   logic              clk;
   logic              rstn;
   logic              we;
   logic              wt;
   logic              flt;
   logic              chk;
   ocp_pkg::ocp_sel_e ws;
   logic [15:0]       wd;
   logic [15:0]       rc;
   logic [15:0]       rp;
   logic [15:0]       rs;
   logic              pin;
   logic              oen;
   wire               pw;
   int                fail_count;
   int                check_count;
   int                cnt[2];
   int                per[2];
   int                on[2];
   int                md, ts, pri, sec, mp, arm, sc;
   assign pw = oen ? 1'bz : pin;
   ocp_if link (.clk(clk), .rstn(rstn));
   ocp_host u_ocp_host (.clk(clk), .rstn(rstn), .bus(link), .user_wr_en(we), .user_wr_sel(ws),
      .user_wr_timer(wt), .user_wr_data(wd), .user_control(rc), .user_primary(rp), .user_secondary(rs));
   ocp_chan u_ocp_chan (.clk(clk), .rstn(rstn), .bus(link), .fault_input_pins(flt),
      .compare_output_pin(pin), .compare_output_oe_n(oen));
   ocp_props u_ocp_props (.clk(clk), .rstn(rstn), .first_timer_count(link.first_timer_count),
      .second_timer_count(link.second_timer_count), .first_timer_wrap(link.first_timer_wrap),
      .second_timer_wrap(link.second_timer_wrap), .wr_en(link.wr_en), .wr_sel(link.wr_sel),
      .wr_data(link.wr_data), .compare_control_reg(link.compare_control_reg),
      .primary_compare_value(link.primary_compare_value),
      .secondary_compare_value(link.secondary_compare_value), .fault_input_pins(flt),
      .compare_output_pin(pin), .compare_output_oe_n(oen));
   // ****************
   // cycle model
   // ****************
   always @(posedge clk) begin
      if (rstn) begin
         sc = ts ? cnt[1] : cnt[0];
         if (md == 0) mp = 0;
         else if (md < 4) begin
            if (sc == pri) mp = (md == 3) ? !mp : md - 1;
         end else if (md < 6) begin
            if ((md == 5 || arm) && sc == pri) mp = 1;
            else if (mp && sc == sec) begin
               mp = 0;
               arm = 0;
            end
         end else if (on[ts] && sc == per[ts]) begin
            pri = sec;
            mp = 1;
         end else if (sc == pri) mp = 0;
         for (int t = 0; t < 2; t++)
            if (on[t]) cnt[t] = (cnt[t] == per[t]) ? 0 : cnt[t] + 1;
         if (we) case (ws)
            ocp_pkg::OCP_SEL_CTL: begin
               md = wd[2:0];
               ts = wd[3];
               arm = 1;
            end
            ocp_pkg::OCP_SEL_PRI: if (md < 6) pri = wd;
            ocp_pkg::OCP_SEL_SEC: sec = wd;
            default: begin
               on[wt] = wd[15];
               per[wt] = wd[14:0];
               if (!wd[15]) cnt[wt] = 0;
            end
         endcase
      end
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   always @(negedge clk) begin
      if (rstn) begin
         cmp(rp, pri);
         cmp(rs, sec);
         cmp(rc[3:0], {ts[0], md[2:0]});
         if (chk) cmp(pw, mp);
      end
   end
   // ****************
   // sequence
   // ****************
   // writes are spaced by one idle cycle so the strobe is never set twice in a step
   task automatic wr(input int s, input int t, input int d);
      ws = ocp_pkg::ocp_sel_e'(s);
      wt = 1'(t);
      wd = 16'(d);
      we = 1;
      @(posedge clk);
      #1;
      we = 0;
      @(posedge clk);
      #1;
   endtask
   task automatic w(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic tally_and_finish;
      if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      clk = 0;
      forever #5 clk = !clk;
   end
   initial begin
      {rstn, we, wt, wd, flt, chk} = 21'h000003;
      ws = ocp_pkg::OCP_SEL_CTL;
      fail_count = 0;
      check_count = 0;
      void'($urandom(32'hC48B1754));
      repeat (12) @(posedge clk);
      #1;
      rstn = 1;
      wr(3, 0, 16'h8028);
      wr(3, 1, 16'h8019);
      for (int m = 1; m < 4; m++)
         for (int t = 0; t < 2; t++) begin
            wr(1, 0, $urandom_range(24));
            wr(0, 0, m | (t << 3));
            w(60);
         end
      wr(1, 0, 16'h0032);
      w(90);
      // pulse set-up with the timer stopped, so the start count is known
      wr(3, 0, 16'h0000);
      wr(1, 0, 16'h0005);
      wr(2, 0, 16'h000F);
      wr(3, 0, 16'h001E);
      wr(0, 0, 16'h0004);
      wr(3, 0, 16'h801E);
      w(80);
      wr(0, 0, 16'h0004);
      w(80);
      wr(0, 0, 16'h0005);
      w(80);
      wr(3, 0, 16'h001E);
      wr(2, 0, $urandom_range(29, 1));
      wr(0, 0, 16'h0006);
      wr(3, 0, 16'h801E);
      w(70);
      wr(2, 0, $urandom_range(29, 1));
      wr(1, 0, 16'h0003);
      w(70);
      wr(0, 0, 16'h0007);
      w(40);
      chk = 0;
      flt = 0;
      w(6);
      cmp(oen, 1);
      cmp(rc[4], 1);
      flt = 1;
      w(5);
      cmp(oen, 1);
      wr(0, 0, 16'h0007);
      w(3);
      cmp(oen, 0);
      cmp(rc[4], 0);
      w(40);
      chk = 1;
      w(40);
      tally_and_finish();
   end
endmodule
